// ### rtl/pwr_mode_ctrl.sv
// operating mode controller and interrupt reporter of the analog die
// Operation
// - modes normal, stop and sleep; stop and sleep are wakeable low-power modes
// - stop keeps regulator on with limited current; sleep turns it off
// - leaving stop raises a wake interrupt; regulator stays on
// - leaving sleep restores regulator then resets host, no interrupt
// - host selects mode by writing the two-bit mode select field
// - wake events: wake input change, lin wake, select rising edge in stop
// - watchdog fails on missing trigger or trigger in closed window; resets
// - watchdog fully off while its config input is grounded
// - normal request: reset high, outputs and lin on, 150 ms timeout
// - normal: reset high, windowed watchdog, outputs lin and amplifier active
// - stop: reset high, watchdog and outputs off, lin recessive with wake
// - each fault reported as interrupt pulse, not a level
// - three unmaskable interrupt sources in normal mode
// - source field set per interrupt, read once then cleared
// - undervoltage sets flag and interrupts; flag follows condition
// - overvoltage sets flag and interrupts; flag follows condition
// - voltage detection, flags and interrupts disabled in stop and sleep
// - in stop, wake inputs and lin wakes interrupt unmaskably
// - watchdog served by normal and trigger mode writes; first service has no closed window
// - lin wake sets lin wake flag in stop and sleep
`timescale 1ns/100ps
module pwr_mode_ctrl
  import pwr_mode_pkg::*;
#(
  parameter int FIRST_CYC = REQ_TIMEOUT_CYC,
  parameter int PERIOD_CYC = WD_PERIOD_CYC,
  parameter int PULSE_CYC = IRQ_PULSE_CYC
)
(
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_srst,
  // spi control write
  input wire logic i_mode_wr,
  input wire logic [1:0] i_mode_select_field,
  // spi status read, one cycle per completed status transfer
  input wire logic i_status_rd,
  // watchdog configuration
  input wire logic i_watchdog_config_input,
  // analog comparators and wake sources
  input wire logic i_primary_supply_low,
  input wire logic i_primary_supply_high,
  input wire logic i_aux_fault,
  input wire logic i_wake_input_one,
  input wire logic i_wake_input_two,
  input wire logic i_lin_wake,
  input wire logic i_spi_sel,
  // host lines
  output logic o_reset_n,
  output logic o_irq_n,
  // status
  output logic [2:0] o_interrupt_source_field,
  output logic o_undervoltage_flag,
  output logic o_overvoltage_flag,
  output logic o_lin_wake_flag,
  output logic [2:0] o_mode_state,
  // power and function enables
  output logic o_reg_on,
  output logic o_reg_limited,
  output logic o_high_side_en,
  output logic o_lin_tx_en,
  output logic o_sense_amp_en
);

  // ************************************************************
  // mode state machine
  // ************************************************************
  mode_state_e state_reg;
  mode_state_e state_next;
  logic wd_fail;
  logic wd_run;
  logic kick;
  logic [3:0] wake_ev;
  logic any_wake;
  logic undervolt_irq;
  logic overvolt_irq;
  logic aux_irq;
  logic detect_on;

  assign kick = i_mode_wr && (i_mode_select_field == MODE_TRIGGER ||
    i_mode_select_field == MODE_NORMAL);
  assign any_wake = |wake_ev;
  assign detect_on = (state_reg == ST_NORM_REQ) || (state_reg == ST_NORMAL);

  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      ST_RESET: state_next = ST_NORM_REQ;
      ST_NORM_REQ:
      begin
        if (wd_fail)
          state_next = ST_RESET;
        else if (kick)
          state_next = ST_NORMAL;
      end
      ST_NORMAL:
      begin
        if (wd_fail)
          state_next = ST_RESET;
        else if (i_mode_wr && i_mode_select_field == MODE_STOP)
          state_next = ST_STOP;
        else if (i_mode_wr && i_mode_select_field == MODE_SLEEP)
          state_next = ST_SLEEP;
      end
      ST_STOP:
      begin
        if (any_wake)
          state_next = ST_NORM_REQ;
      end
      ST_SLEEP:
      begin
        if (any_wake)
          state_next = ST_RESET;
      end
      default: state_next = ST_RESET;
    endcase
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst)
      state_reg <= ST_RESET;
    else
      state_reg <= state_next;
  end

  // ************************************************************
  // mode outputs
  // ************************************************************
  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst)
    begin
      o_reset_n <= 1'b0;
      o_reg_on <= 1'b1;
      o_reg_limited <= 1'b0;
      o_high_side_en <= 1'b0;
      o_lin_tx_en <= 1'b0;
      o_sense_amp_en <= 1'b0;
      o_mode_state <= 3'h0;
    end
    else
    begin
      o_reset_n <= (state_next != ST_RESET) && (state_next != ST_SLEEP);
      o_reg_on <= state_next != ST_SLEEP;
      o_reg_limited <= state_next == ST_STOP;
      o_high_side_en <= (state_next == ST_NORM_REQ) || (state_next == ST_NORMAL);
      o_lin_tx_en <= (state_next == ST_NORM_REQ) || (state_next == ST_NORMAL);
      o_sense_amp_en <= state_next == ST_NORMAL;
      o_mode_state <= state_next;
    end
  end

  // ************************************************************
  // watchdog
  // ************************************************************
  // grounded config holds the watchdog in reset
  assign wd_run = i_watchdog_config_input && detect_on;

  // fail is registered, so the reset state follows one cycle after the bad kick
  pwr_window_watchdog #(
    .FIRST_CYC(FIRST_CYC),
    .PERIOD_CYC(PERIOD_CYC)
  ) u_wd (
    .i_ref_clk(i_ref_clk),
    .i_srst(i_srst),
    .i_run(wd_run),
    .i_first(state_reg == ST_NORM_REQ),
    .i_kick(kick),
    .o_fail(wd_fail)
  );

  // ************************************************************
  // wake detection
  // ************************************************************
  pwr_wake_detect u_wake (
    .i_ref_clk(i_ref_clk),
    .i_srst(i_srst),
    .i_arm((state_reg == ST_STOP) || (state_reg == ST_SLEEP)),
    .i_sel_en(state_reg == ST_STOP),
    .i_wake_input_one(i_wake_input_one),
    .i_wake_input_two(i_wake_input_two),
    .i_lin_wake(i_lin_wake),
    .i_spi_sel(i_spi_sel),
    .o_event(wake_ev)
  );

  // ************************************************************
  // fault flags
  // ************************************************************
  logic uv_last_reg;
  logic ov_last_reg;
  logic aux_last_reg;

  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst || !detect_on)
    begin
      o_undervoltage_flag <= 1'b0;
      o_overvoltage_flag <= 1'b0;
      uv_last_reg <= 1'b0;
      ov_last_reg <= 1'b0;
      aux_last_reg <= 1'b0;
    end
    else
    begin
      o_undervoltage_flag <= i_primary_supply_low;
      o_overvoltage_flag <= i_primary_supply_high;
      uv_last_reg <= i_primary_supply_low;
      ov_last_reg <= i_primary_supply_high;
      aux_last_reg <= i_aux_fault;
    end
  end

  // interrupts fire on the onset of each condition
  assign undervolt_irq = detect_on && i_primary_supply_low && !uv_last_reg;
  assign overvolt_irq = detect_on && i_primary_supply_high && !ov_last_reg;
  assign aux_irq = detect_on && i_aux_fault && !aux_last_reg;

  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst)
      o_lin_wake_flag <= 1'b0;
    else if (wake_ev[2])
      o_lin_wake_flag <= 1'b1;
    else if (i_status_rd)
      o_lin_wake_flag <= 1'b0;
  end

  // ************************************************************
  // interrupt pulse and source field
  // ************************************************************
  logic stop_irq;
  logic any_irq;
  logic [2:0] src;
  logic [7:0] pulse_cnt_reg;

  // sleep wakes give a reset, not an interrupt
  assign stop_irq = (state_reg == ST_STOP) && any_wake;
  assign any_irq = undervolt_irq || overvolt_irq || aux_irq || stop_irq;

  always_comb
  begin
    src = SRC_NONE;
    if (stop_irq)
    begin
      if (wake_ev[0])
        src = SRC_WAKE_ONE;
      else if (wake_ev[1])
        src = SRC_WAKE_TWO;
      else if (wake_ev[2])
        src = SRC_LIN_WAKE;
      else
        src = SRC_SEL_WAKE;
    end
    else if (undervolt_irq)
      src = SRC_UNDERVOLT;
    else if (overvolt_irq)
      src = SRC_OVERVOLT;
    else if (aux_irq)
      src = SRC_AUX;
  end

  // a new source wins over a read-clear in the same cycle
  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst)
      o_interrupt_source_field <= SRC_NONE;
    else if (any_irq)
      o_interrupt_source_field <= src;
    else if (i_status_rd)
      o_interrupt_source_field <= SRC_NONE;
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst)
    begin
      pulse_cnt_reg <= 8'h0;
      o_irq_n <= 1'b1;
    end
    else if (any_irq)
    begin
      pulse_cnt_reg <= 8'(PULSE_CYC - 1);
      o_irq_n <= 1'b0;
    end
    else if (pulse_cnt_reg != 8'h0)
    begin
      pulse_cnt_reg <= pulse_cnt_reg - 8'h1;
      o_irq_n <= 1'b0;
    end
    else
    begin
      o_irq_n <= 1'b1;
    end
  end

endmodule

// ### rtl/pwr_mode_pkg.sv
// constants and types shared by the mode controller and its helpers
package pwr_mode_pkg;

  // ************************************************************
  // mode select field codes
  // ************************************************************
  localparam logic [1:0] MODE_NORMAL = 2'h0;
  localparam logic [1:0] MODE_STOP = 2'h1;
  localparam logic [1:0] MODE_SLEEP = 2'h2;
  localparam logic [1:0] MODE_TRIGGER = 2'h3;

  // ************************************************************
  // interrupt source field codes
  // ************************************************************
  localparam logic [2:0] SRC_NONE = 3'h0;
  localparam logic [2:0] SRC_UNDERVOLT = 3'h1;
  localparam logic [2:0] SRC_OVERVOLT = 3'h2;
  localparam logic [2:0] SRC_WAKE_ONE = 3'h3;
  localparam logic [2:0] SRC_WAKE_TWO = 3'h4;
  localparam logic [2:0] SRC_LIN_WAKE = 3'h5;
  localparam logic [2:0] SRC_SEL_WAKE = 3'h6;
  localparam logic [2:0] SRC_AUX = 3'h7;

  // ************************************************************
  // timing
  // ************************************************************
  localparam int CLK_HZ = 50_000_000;
  localparam int REQ_TIMEOUT_MS = 150;
  localparam int REQ_TIMEOUT_CYC = REQ_TIMEOUT_MS * (CLK_HZ / 1000);
  localparam int WD_PERIOD_MS = 150;
  localparam int WD_PERIOD_CYC = WD_PERIOD_MS * (CLK_HZ / 1000);
  localparam int IRQ_PULSE_CYC = 4;

  typedef enum logic [2:0] {
    ST_RESET = 3'b000,
    ST_NORM_REQ = 3'b001,
    ST_NORMAL = 3'b011,
    ST_STOP = 3'b010,
    ST_SLEEP = 3'b110
  } mode_state_e;

endpackage

// ### rtl/pwr_window_watchdog.sv
// windowed watchdog with an open-only first period
`timescale 1ns/100ps
module pwr_window_watchdog
  import pwr_mode_pkg::*;
#(
  parameter int FIRST_CYC = REQ_TIMEOUT_CYC,
  parameter int PERIOD_CYC = WD_PERIOD_CYC
)
(
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_srst,
  // control
  input wire logic i_run,
  input wire logic i_first,
  input wire logic i_kick,
  // status
  output logic o_fail
);

  logic [31:0] count_reg;
  logic closed;

  // closed part is the first half of each normal period
  assign closed = !i_first && (count_reg < 32'(PERIOD_CYC / 2));

  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst || !i_run || i_kick)
    begin
      count_reg <= 32'h0;
    end
    else
    begin
      count_reg <= count_reg + 32'h1;
    end
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst || !i_run)
    begin
      o_fail <= 1'b0;
    end
    else
    begin
      o_fail <= (i_kick && closed) ||
        (!i_kick && count_reg >= 32'(i_first ? FIRST_CYC - 1 : PERIOD_CYC - 1));
    end
  end

endmodule

// ### rtl/pwr_wake_detect.sv
// wake event detection on the wake inputs, lin and select line
`timescale 1ns/100ps
module pwr_wake_detect
(
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_srst,
  // control
  input wire logic i_arm,
  input wire logic i_sel_en,
  // sources
  input wire logic i_wake_input_one,
  input wire logic i_wake_input_two,
  input wire logic i_lin_wake,
  input wire logic i_spi_sel,
  // events
  output logic [3:0] o_event
);

  logic [3:0] now;
  logic [3:0] last_reg;
  logic armed_reg;

  assign now = {i_spi_sel, i_lin_wake, i_wake_input_two, i_wake_input_one};

  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst)
    begin
      last_reg <= 4'h0;
      armed_reg <= 1'b0;
    end
    else
    begin
      last_reg <= now;
      armed_reg <= i_arm;
    end
  end

  // the first armed cycle only takes a reference, so no stale edge wakes us
  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst || !i_arm || !armed_reg)
    begin
      o_event <= 4'h0;
    end
    else
    begin
      o_event[0] <= now[0] ^ last_reg[0];
      o_event[1] <= now[1] ^ last_reg[1];
      o_event[2] <= i_lin_wake && !last_reg[2];
      o_event[3] <= i_sel_en && i_spi_sel && !last_reg[3];
    end
  end

endmodule

// ### verif/pwr_mode_ctrl_asserts.sv
// assertions on the mode controller ports
`timescale 1ns/100ps
module pwr_mode_ctrl_asserts
  import pwr_mode_pkg::*;
(
  // clock, reset and comparators
  input wire logic i_ref_clk,
  input wire logic i_srst,
  input wire logic i_primary_supply_low,
  input wire logic i_primary_supply_high,
  // observed outputs
  input wire logic o_reset_n,
  input wire logic o_irq_n,
  input wire logic o_undervoltage_flag,
  input wire logic o_overvoltage_flag,
  input wire logic [2:0] o_mode_state,
  input wire logic o_reg_on,
  input wire logic o_reg_limited,
  input wire logic o_high_side_en,
  input wire logic o_lin_tx_en,
  input wire logic o_sense_amp_en
);
  // ******************************
  // mode, flag and interrupt relations
  // ******************************
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_srst);
  off_states_a: assert property ((o_mode_state == ST_RESET || o_mode_state == ST_SLEEP)
    |-> !o_reset_n && !o_high_side_en && !o_lin_tx_en) else $error("reset state outputs wrong");
  stop_outs_a: assert property (o_mode_state == ST_STOP |-> o_reset_n && o_reg_on
    && o_reg_limited && !o_high_side_en && !o_lin_tx_en && !o_sense_amp_en)
    else $error("stop outputs wrong");
  sleep_reg_a: assert property (o_mode_state == ST_SLEEP |-> !o_reg_on)
    else $error("regulator on in sleep");
  normreq_outs_a: assert property (o_mode_state == ST_NORM_REQ |-> o_reset_n
    && o_high_side_en && o_lin_tx_en && !o_sense_amp_en) else $error("request outputs wrong");
  normal_outs_a: assert property (o_mode_state == ST_NORMAL |-> o_reset_n
    && o_high_side_en && o_lin_tx_en && o_sense_amp_en) else $error("normal outputs wrong");
  irq_pulse_a: assert property ($fell(o_irq_n) |-> !o_irq_n [*4])
    else $error("interrupt pulse too short");
  flags_off_a: assert property ((o_mode_state == ST_STOP || o_mode_state == ST_SLEEP)
    && $past(o_mode_state) == o_mode_state |-> !o_undervoltage_flag && !o_overvoltage_flag)
    else $error("voltage flag set in low power");
  uv_follow_a: assert property (o_mode_state == ST_NORMAL && $past(o_mode_state) == ST_NORMAL
    |-> o_undervoltage_flag == $past(i_primary_supply_low)) else $error("undervoltage flag wrong");
  ov_follow_a: assert property (o_mode_state == ST_NORMAL && $past(o_mode_state) == ST_NORMAL
    |-> o_overvoltage_flag == $past(i_primary_supply_high)) else $error("overvoltage flag wrong");
  stop_exit_a: assert property ($past(o_mode_state) == ST_STOP && o_mode_state == ST_NORM_REQ
    |-> !o_irq_n) else $error("stop exit without interrupt");
  sleep_exit_a: assert property ($past(o_mode_state) == ST_SLEEP && o_mode_state != ST_SLEEP
    |-> o_mode_state == ST_RESET && o_irq_n) else $error("sleep exit wrong");
  stop_c: cover property (o_mode_state == ST_STOP);
  sleep_c: cover property (o_mode_state == ST_SLEEP);
  irq_c: cover property ($fell(o_irq_n));
endmodule

bind pwr_mode_ctrl pwr_mode_ctrl_asserts pwr_mode_ctrl_asserts_i (.*);

// ### verif/pwr_host_model.sv
// host side model: spi mode writes and status transfers
`timescale 1ns/100ps
module pwr_host_model
  import pwr_mode_pkg::*;
(
  // clock
  input wire logic i_ref_clk,
  // spi strobes
  output logic o_mode_wr,
  output logic [1:0] o_mode_select_field,
  output logic o_status_rd
);
  // ******************************
  // transfers
  // ******************************
  initial
  begin
    o_mode_wr = 1'b0;
    o_mode_select_field = 2'h2;
    o_status_rd = 1'b0;
  end
  // field is inverted once the strobe drops so a stale value is never read
  task automatic write_mode(input logic [1:0] f);
    @(negedge i_ref_clk);
    o_mode_select_field = f;
    o_mode_wr = 1'b1;
    @(negedge i_ref_clk);
    o_mode_wr = 1'b0;
    o_mode_select_field = ~f;
  endtask
  task automatic read_status();
    @(negedge i_ref_clk);
    o_status_rd = 1'b1;
    @(negedge i_ref_clk);
    o_status_rd = 1'b0;
  endtask
endmodule

// ### verif/tb_pwr_mode_ctrl.sv
// self-checking bench for the mode controller
`timescale 1ns/100ps
module tb_pwr_mode_ctrl
  import pwr_mode_pkg::*;
;
  // ******************************
  // design and host
  // ******************************
  logic i_ref_clk = 1'b0;
  logic i_srst = 1'b1;
  logic i_mode_wr, i_status_rd;
  logic [1:0] i_mode_select_field;
  logic i_watchdog_config_input = 1'b1;
  logic i_primary_supply_low = 1'b0, i_primary_supply_high = 1'b0, i_aux_fault = 1'b0;
  logic i_wake_input_one = 1'b0, i_wake_input_two = 1'b0, i_lin_wake = 1'b0, i_spi_sel = 1'b0;
  logic o_reset_n, o_irq_n, o_undervoltage_flag, o_overvoltage_flag, o_lin_wake_flag;
  logic [2:0] o_interrupt_source_field, o_mode_state;
  logic o_reg_on, o_reg_limited, o_high_side_en, o_lin_tx_en, o_sense_amp_en;
  int miscompares = 0;
  int tests_run = 0;
  always #10 i_ref_clk = ~i_ref_clk;
  // short counts keep the watchdog scenarios brief
  pwr_mode_ctrl #(.FIRST_CYC(100), .PERIOD_CYC(200), .PULSE_CYC(4)) pwr_mode_ctrl_i (.*);
  pwr_host_model pwr_host_model_i (.i_ref_clk(i_ref_clk), .o_mode_wr(i_mode_wr),
    .o_mode_select_field(i_mode_select_field), .o_status_rd(i_status_rd));
  task automatic chk(input string nm, input logic [2:0] seen, input logic [2:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wait_st(input logic [2:0] s);
    int n;
    n = 0;
    while (o_mode_state !== s && n < 400)
    begin
      @(negedge i_ref_clk);
      n++;
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // ******************************
  // scenarios
  // ******************************
  task automatic t_stop_wake(input logic [2:0] code);
    pwr_host_model_i.write_mode(MODE_NORMAL);
    chk("state", o_mode_state, ST_NORMAL);
    pwr_host_model_i.write_mode(MODE_STOP);
    chk("state", o_mode_state, ST_STOP);
    chk("limited", {2'h0, o_reg_limited}, 3'h1);
    repeat (3) @(negedge i_ref_clk);
    case (code)
      SRC_WAKE_ONE: i_wake_input_one = ~i_wake_input_one;
      SRC_WAKE_TWO: i_wake_input_two = ~i_wake_input_two;
      SRC_LIN_WAKE: i_lin_wake = 1'b1;
      default: i_spi_sel = 1'b1;
    endcase
    wait_st(ST_NORM_REQ);
    chk("state", o_mode_state, ST_NORM_REQ);
    chk("irq", {2'h0, o_irq_n}, 3'h0);
    chk("source", o_interrupt_source_field, code);
    if (code == SRC_LIN_WAKE)
      chk("lin flag", {2'h0, o_lin_wake_flag}, 3'h1);
    i_lin_wake = 1'b0;
    i_spi_sel = 1'b0;
    pwr_host_model_i.read_status();
    chk("source", o_interrupt_source_field, SRC_NONE);
    $display("stop wake %0d done", code);
  endtask
  task automatic t_sleep();
    pwr_host_model_i.write_mode(MODE_TRIGGER);
    pwr_host_model_i.write_mode(MODE_SLEEP);
    chk("state", o_mode_state, ST_SLEEP);
    chk("regulator", {2'h0, o_reg_on}, 3'h0);
    repeat (3) @(negedge i_ref_clk);
    i_lin_wake = 1'b1;
    wait_st(ST_RESET);
    chk("state", o_mode_state, ST_RESET);
    chk("reset", {2'h0, o_reset_n}, 3'h0);
    chk("irq", {2'h0, o_irq_n}, 3'h1);
    wait_st(ST_NORM_REQ);
    chk("state", o_mode_state, ST_NORM_REQ);
    chk("lin flag", {2'h0, o_lin_wake_flag}, 3'h1);
    i_lin_wake = 1'b0;
    pwr_host_model_i.read_status();
    chk("lin flag", {2'h0, o_lin_wake_flag}, 3'h0);
    $display("sleep wake done");
  endtask
  task automatic t_volt();
    pwr_host_model_i.write_mode(MODE_TRIGGER);
    i_primary_supply_low = 1'b1;
    repeat (2) @(negedge i_ref_clk);
    chk("uv flag", {2'h0, o_undervoltage_flag}, 3'h1);
    chk("irq", {2'h0, o_irq_n}, 3'h0);
    chk("source", o_interrupt_source_field, SRC_UNDERVOLT);
    // condition still present: the line must be back high, the flag still set
    repeat (4) @(negedge i_ref_clk);
    chk("irq", {2'h0, o_irq_n}, 3'h1);
    chk("uv flag", {2'h0, o_undervoltage_flag}, 3'h1);
    i_primary_supply_low = 1'b0;
    pwr_host_model_i.read_status();
    i_primary_supply_high = 1'b1;
    repeat (2) @(negedge i_ref_clk);
    chk("ov flag", {2'h0, o_overvoltage_flag}, 3'h1);
    chk("source", o_interrupt_source_field, SRC_OVERVOLT);
    i_primary_supply_high = 1'b0;
    pwr_host_model_i.read_status();
    i_aux_fault = 1'b1;
    repeat (2) @(negedge i_ref_clk);
    chk("source", o_interrupt_source_field, SRC_AUX);
    i_aux_fault = 1'b0;
    pwr_host_model_i.read_status();
    pwr_host_model_i.write_mode(MODE_STOP);
    i_primary_supply_low = 1'b1;
    // two cycles: a wrongly raised pulse would still be low here
    repeat (2) @(negedge i_ref_clk);
    chk("uv flag", {2'h0, o_undervoltage_flag}, 3'h0);
    chk("irq", {2'h0, o_irq_n}, 3'h1);
    chk("source", o_interrupt_source_field, SRC_NONE);
    i_primary_supply_low = 1'b0;
    i_wake_input_one = ~i_wake_input_one;
    wait_st(ST_NORM_REQ);
    pwr_host_model_i.read_status();
    $display("voltage done");
  endtask
  task automatic t_wdog();
    wait_st(ST_RESET);
    chk("state", o_mode_state, ST_RESET);
    wait_st(ST_NORM_REQ);
    pwr_host_model_i.write_mode(MODE_NORMAL);
    pwr_host_model_i.write_mode(MODE_TRIGGER);
    wait_st(ST_RESET);
    chk("state", o_mode_state, ST_RESET);
    wait_st(ST_NORM_REQ);
    i_watchdog_config_input = 1'b0;
    repeat (300) @(negedge i_ref_clk);
    chk("state", o_mode_state, ST_NORM_REQ);
    pwr_host_model_i.write_mode(MODE_NORMAL);
    repeat (300) @(negedge i_ref_clk);
    chk("state", o_mode_state, ST_NORMAL);
    // no kick at all in normal: the period runs out
    i_watchdog_config_input = 1'b1;
    wait_st(ST_RESET);
    chk("state", o_mode_state, ST_RESET);
    $display("watchdog done");
  endtask
  initial
  begin
    repeat (10) @(negedge i_ref_clk);
    i_srst = 1'b0;
    @(negedge i_ref_clk);
    chk("state", o_mode_state, ST_NORM_REQ);
    t_stop_wake(SRC_WAKE_ONE);
    t_stop_wake(SRC_WAKE_TWO);
    t_stop_wake(SRC_LIN_WAKE);
    t_stop_wake(SRC_SEL_WAKE);
    t_sleep();
    t_volt();
    t_wdog();
    wrap_up();
  end
  initial
  begin
    #100000;
    miscompares++;
    wrap_up();
  end
endmodule
